// ===== dspwm_defines.svh
// Constants for the dual-slope PWM timer: register offsets, field positions,
// reset values, mode codes and prescaler masks.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DSPWM_DEFINES_SVH
`define DSPWM_DEFINES_SVH

// Register byte offsets on the APB bus.
`define DSPWM_OFS_CTRL      12'h000
`define DSPWM_OFS_COUNT     12'h004
`define DSPWM_OFS_CAPTOP    12'h008
`define DSPWM_OFS_CMP_A     12'h00c
`define DSPWM_OFS_CMP_B     12'h010
`define DSPWM_OFS_CMP_C     12'h014
`define DSPWM_OFS_FLAGS     12'h018

// Control register field positions.
`define DSPWM_CTRL_WGM_LSB  0
`define DSPWM_CTRL_CS_LSB   4
`define DSPWM_CTRL_COM_LSB  8
`define DSPWM_CTRL_DIR_LSB  16

// Flag register bit positions; compare flags follow from the given bit.
`define DSPWM_FLG_OVF       0
`define DSPWM_FLG_CAPT      1
`define DSPWM_FLG_CMP_LSB   2

// Reset values.
`define DSPWM_CTRL_RST      32'h0000_0000
`define DSPWM_VAL_RST       16'h0000

// Waveform-select codes used by the dual-slope modes.
`define DSPWM_WGM_PC8       4'h1
`define DSPWM_WGM_PC9       4'h2
`define DSPWM_WGM_PC10      4'h3
`define DSPWM_WGM_PFC_CAP   4'h8
`define DSPWM_WGM_PFC_A     4'h9
`define DSPWM_WGM_PC_CAP    4'ha
`define DSPWM_WGM_PC_A      4'hb

// Fixed TOP values of the phase correct modes.
`define DSPWM_TOP_8BIT      16'h00ff
`define DSPWM_TOP_9BIT      16'h01ff
`define DSPWM_TOP_10BIT     16'h03ff

// Output-select codes.
`define DSPWM_COM_TOGGLE    2'h1
`define DSPWM_COM_NONINV    2'h2
`define DSPWM_COM_INV       2'h3

// Prescaler: clock-select codes and low-bit masks of the free-running divider.
`define DSPWM_CS_STOP       3'h0
`define DSPWM_CS_DIV1       3'h1
`define DSPWM_CS_DIV8       3'h2
`define DSPWM_CS_DIV64      3'h3
`define DSPWM_CS_DIV256     3'h4
`define DSPWM_CS_DIV1024    3'h5
`define DSPWM_MASK_DIV8     10'h007
`define DSPWM_MASK_DIV64    10'h03f
`define DSPWM_MASK_DIV256   10'h0ff
`define DSPWM_MASK_DIV1024  10'h3ff

`endif

// ===== dspwm_pkg.sv
// Types shared by the dual-slope PWM timer modules.
// Assumes the defines header is on the include path.
`default_nettype none
`include "dspwm_defines.svh"

package dspwm_pkg;

	// Count direction of the dual-slope counter.
	typedef enum logic {
		DSPWM_DIR_UP,
		DSPWM_DIR_DOWN
	} dspwm_dir_e;

	// Kind of counting selected by the waveform-select code.
	typedef enum logic [1:0] {
		DSPWM_KIND_OFF,
		DSPWM_KIND_PC,
		DSPWM_KIND_PFC
	} dspwm_kind_e;

	// Per-channel configuration handed to each compare channel.
	typedef struct packed {
		logic [1:0] output_select_field;	// Output mode of the channel.
		logic       buffered;			// Writes go to the buffer.
		logic       toggle_ok;			// Toggle mode allowed here.
	} dspwm_chan_cfg_s;

endpackage
`default_nettype wire

// ===== dspwm_channel.sv
// One compare channel: buffer and active compare value, match detection and
// the compare output register of the dual-slope waveform.
// Assumes the timer tick is a one-cycle enable in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "dspwm_defines.svh"

module dspwm_channel #(
	parameter int CNT_W = 16
) (
	// Clock and reset.
	input  wire logic                     clk,
	input  wire logic                     resetn,
	// Timing from the counter.
	input  wire logic                     timer_tick,
	input  wire logic                     update_now,
	input  wire logic [CNT_W-1:0]         counter_value,
	input  wire logic [CNT_W-1:0]         top_value,
	input  wire dspwm_pkg::dspwm_dir_e    dir,
	// Configuration and software write.
	input  wire dspwm_pkg::dspwm_chan_cfg_s cfg,
	input  wire logic                     wr_en,
	input  wire logic [CNT_W-1:0]         wr_data,
	// Results.
	output logic [CNT_W-1:0]              buf_value,
	output logic [CNT_W-1:0]              compare_value_reg,
	output logic                          match,
	output logic                          out_level
);
	import dspwm_pkg::*;

	logic [CNT_W-1:0] buf_r, buf_nxt;	// Value last written by software.
	logic [CNT_W-1:0] act_r, act_nxt;	// Value the comparator uses.
	logic             out_r, out_nxt;	// Compare output register.
	logic             inv;			// Inverted output selected.

	// A match counts only on a tick, on either slope.
	// match on both slopes
	assign match             = timer_tick && (counter_value == act_r);
	assign inv               = (cfg.output_select_field == `DSPWM_COM_INV);
	assign buf_value         = buf_r;
	assign compare_value_reg = act_r;
	assign out_level         = out_r;

	// Next compare values: writes land in the buffer, the active copy follows
	// at the update point, or at once when the mode is not buffered.
	always_comb begin
		buf_nxt = buf_r;
		act_nxt = act_r;
		if (wr_en) begin
			buf_nxt = wr_data;
		end
		if (!cfg.buffered) begin
			act_nxt = buf_nxt;
		end else if (update_now) begin
			act_nxt = buf_r;
		end
	end

	// Next output level, decided only on a tick.
	always_comb begin
		out_nxt = out_r;
		if (timer_tick) begin
			unique case (cfg.output_select_field)
				`DSPWM_COM_NONINV, `DSPWM_COM_INV: begin
					if (act_r == '0) begin
						out_nxt = inv;
					end else if (act_r >= top_value) begin
						out_nxt = !inv;
					end else if (match) begin
						out_nxt = (dir == DSPWM_DIR_UP) ? inv : !inv;
					end
				end
				`DSPWM_COM_TOGGLE: begin
					if (cfg.toggle_ok && match) begin
						out_nxt = !out_r;
					end
				end
				default: begin
					out_nxt = out_r;
				end
			endcase
		end
	end

	// Register the channel state.
	// output starts low
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			buf_r <= '0;
			act_r <= '0;
			out_r <= 1'b0;
		end else begin
			buf_r <= buf_nxt;
			act_r <= act_nxt;
			out_r <= out_nxt;
		end
	end

endmodule
`default_nettype wire

// ===== dspwm_timer.sv
// Dual-slope PWM timer: prescaler, up/down counter, TOP selection, flags,
// compare channels, pin drive and an APB register slave.
// Assumes APB signals are synchronous to clk and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "dspwm_defines.svh"

// Behaviour
// - Output-select two non-inverted, three inverted
// - Pin driven only when direction bit set
// - Up-slope match and down-slope match opposite
// - Counter advances on prescaled tick
// - Compare BOTTOM low, TOP high when non-inverted; BOTTOM high, TOP low when inverted
// - Mode 11 toggle gives 50% duty
// - Mode 9 toggle gives 50% duty
// - Codes 8 and 9 frequency correct
// - TOP from capture or channel A
// - Counter turns at TOP without holding it
// - TOP from 0x0003 to full range
// - Compare flag on match, both slopes
// - Frequency correct: update and overflow at BOTTOM
// - TOP-defining flag set at TOP
// - Frequency correct slopes stay symmetrical
// - Fully synchronous, tick is clock enable
// - Codes 1,2,3,10,11 phase correct
// - Phase correct TOP fixed or register
// - Phase correct: update at TOP, overflow at BOTTOM
module dspwm_timer #(
	parameter int CNT_W  = 16,
	parameter int NUM_CH = 3
) (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              resetn,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Compare output pins, channel A first.
	output logic [NUM_CH-1:0]      compare_output_pin,
	output logic [NUM_CH-1:0]      compare_output_oe
);
	import dspwm_pkg::*;

	// Refuse widths the fixed TOP values or register fields cannot serve.
	if (CNT_W < 10 || CNT_W > 32 || NUM_CH < 1 || NUM_CH > 3) begin : g_bad_param
		$error("dspwm_timer: CNT_W must be 10..32 and NUM_CH 1..3");
	end

	// Control register and its fields.
	logic [31:0]           ctrl_r, ctrl_nxt;
	logic [3:0]            waveform_select;
	logic [2:0]            clk_select;
	logic [NUM_CH-1:0]     pin_direction_bit;
	// Capture TOP register, not buffered.
	logic [CNT_W-1:0]      capture_top_reg_r, capture_top_reg_nxt;
	// Prescaler divider and the tick it makes.
	logic [9:0]            pre_r, pre_nxt;
	logic                  timer_tick;
	// Counter and its direction.
	logic [CNT_W-1:0]      cnt_r, cnt_nxt;
	dspwm_dir_e            dir_r, dir_nxt;
	// Flags: overflow, capture, compare per channel.
	logic                  ovf_r, ovf_nxt;
	logic                  capt_r, capt_nxt;
	logic [NUM_CH-1:0]     cmpf_r, cmpf_nxt;
	// Mode decode and TOP.
	dspwm_kind_e           kind;
	logic [CNT_W-1:0]      top_value;
	logic                  at_top, at_bottom, update_now;
	// Channel results.
	logic [CNT_W-1:0]      ch_buf [NUM_CH];
	logic [CNT_W-1:0]      ch_act [NUM_CH];
	logic [NUM_CH-1:0]     ch_match, ch_out, ch_wr;
	// APB decode.
	logic                  wr_acc, rd_hit;
	logic [31:0]           rd_mux;

	assign waveform_select   = ctrl_r[`DSPWM_CTRL_WGM_LSB +: 4];
	assign clk_select        = ctrl_r[`DSPWM_CTRL_CS_LSB +: 3];
	assign pin_direction_bit = ctrl_r[`DSPWM_CTRL_DIR_LSB +: NUM_CH];

	// Decode the waveform-select code into counting kind.
	always_comb begin
		unique case (waveform_select)
			`DSPWM_WGM_PC8, `DSPWM_WGM_PC9, `DSPWM_WGM_PC10,
			`DSPWM_WGM_PC_CAP, `DSPWM_WGM_PC_A: begin
				kind = DSPWM_KIND_PC;
			end
			`DSPWM_WGM_PFC_CAP, `DSPWM_WGM_PFC_A: begin
				kind = DSPWM_KIND_PFC;
			end
			// Other modes are not served; the counter is held at zero.
			default: begin
				kind = DSPWM_KIND_OFF;
			end
		endcase
	end

	// Select TOP; any register value is accepted, so 0x0003 up to full range works.
	// full TOP range
	always_comb begin
		unique case (waveform_select)
			`DSPWM_WGM_PC8:  top_value = CNT_W'(`DSPWM_TOP_8BIT);
			`DSPWM_WGM_PC9:  top_value = CNT_W'(`DSPWM_TOP_9BIT);
			`DSPWM_WGM_PC10: top_value = CNT_W'(`DSPWM_TOP_10BIT);
			`DSPWM_WGM_PFC_CAP, `DSPWM_WGM_PC_CAP: top_value = capture_top_reg_r;
			`DSPWM_WGM_PFC_A, `DSPWM_WGM_PC_A:     top_value = ch_act[0];
			default:         top_value = {CNT_W{1'b1}};
		endcase
	end

	// Prescaler: free-running divider, tick when the selected low bits are all one.
	// prescaled timer tick
	always_comb begin
		pre_nxt = pre_r + 10'h001;
		unique case (clk_select)
			`DSPWM_CS_DIV1:    timer_tick = 1'b1;
			`DSPWM_CS_DIV8:    timer_tick = &(pre_r | ~`DSPWM_MASK_DIV8);
			`DSPWM_CS_DIV64:   timer_tick = &(pre_r | ~`DSPWM_MASK_DIV64);
			`DSPWM_CS_DIV256:  timer_tick = &(pre_r | ~`DSPWM_MASK_DIV256);
			`DSPWM_CS_DIV1024: timer_tick = &(pre_r | ~`DSPWM_MASK_DIV1024);
			// Stop and unused codes give no tick.
			default:           timer_tick = 1'b0;
		endcase
	end

	// Events seen on the tick at which the counter shows TOP or BOTTOM.
	// tick as clock enable
	assign at_top     = timer_tick && (kind != DSPWM_KIND_OFF) && (cnt_r == top_value);
	assign at_bottom  = timer_tick && (kind != DSPWM_KIND_OFF) && (cnt_r == '0);
	assign update_now = (kind == DSPWM_KIND_PC) ? at_top :
	                    (kind == DSPWM_KIND_PFC) ? at_bottom : 1'b0;

	// Counter next value: up to TOP, turn there without a hold, down to BOTTOM.
	always_comb begin
		cnt_nxt = cnt_r;
		dir_nxt = dir_r;
		if (kind == DSPWM_KIND_OFF) begin
			cnt_nxt = '0;
			dir_nxt = DSPWM_DIR_UP;
		end else if (timer_tick) begin
			unique case (dir_r)
				DSPWM_DIR_UP: begin
					if (cnt_r == top_value) begin
						dir_nxt = DSPWM_DIR_DOWN;
						cnt_nxt = cnt_r - CNT_W'(1);
					end else begin
						// A TOP below the count wraps through the maximum.
						cnt_nxt = cnt_r + CNT_W'(1);
					end
				end
				DSPWM_DIR_DOWN: begin
					if (cnt_r == '0) begin
						dir_nxt = DSPWM_DIR_UP;
						cnt_nxt = CNT_W'(1);
					end else begin
						cnt_nxt = cnt_r - CNT_W'(1);
					end
				end
			endcase
		end
	end

	// APB: zero-wait slave, every access completes in its access phase.
	assign pready  = 1'b1;
	assign wr_acc  = psel && penable && pwrite;

	// Read mux; unmapped addresses return zero with an error.
	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`DSPWM_OFS_CTRL:   rd_mux = ctrl_r;
			`DSPWM_OFS_COUNT:  rd_mux = 32'(cnt_r);
			`DSPWM_OFS_CAPTOP: rd_mux = 32'(capture_top_reg_r);
			`DSPWM_OFS_FLAGS:  rd_mux = 32'({cmpf_r, capt_r, ovf_r});
			`DSPWM_OFS_CMP_A:  rd_mux = 32'(ch_buf[0]);
			`DSPWM_OFS_CMP_B:  rd_mux = (NUM_CH > 1) ? 32'(ch_buf[NUM_CH > 1 ? 1 : 0]) : 32'h0;
			`DSPWM_OFS_CMP_C:  rd_mux = (NUM_CH > 2) ? 32'(ch_buf[NUM_CH > 2 ? 2 : 0]) : 32'h0;
			default:           rd_hit = 1'b0;
		endcase
	end
	assign prdata  = (psel && penable && !pwrite) ? rd_mux : 32'h0000_0000;
	assign pslverr = psel && penable && !rd_hit;

	// Control and capture register writes.
	always_comb begin
		ctrl_nxt            = ctrl_r;
		capture_top_reg_nxt = capture_top_reg_r;
		if (wr_acc && paddr == `DSPWM_OFS_CTRL) begin
			ctrl_nxt = pwdata;
		end
		if (wr_acc && paddr == `DSPWM_OFS_CAPTOP) begin
			capture_top_reg_nxt = pwdata[CNT_W-1:0];
		end
	end

	// Flags: hardware set wins over a write-one-to-clear in the same cycle.
	always_comb begin
		logic [31:0] clr;
		clr      = (wr_acc && paddr == `DSPWM_OFS_FLAGS) ? pwdata : 32'h0000_0000;
		ovf_nxt  = ovf_r && !clr[`DSPWM_FLG_OVF];
		capt_nxt = capt_r && !clr[`DSPWM_FLG_CAPT];
		cmpf_nxt = cmpf_r & ~clr[`DSPWM_FLG_CMP_LSB +: NUM_CH];
		if (at_bottom) begin
			ovf_nxt = 1'b1;
		end
		if (at_top && (waveform_select == `DSPWM_WGM_PFC_CAP ||
		               waveform_select == `DSPWM_WGM_PC_CAP)) begin
			capt_nxt = 1'b1;
		end
		// compare flags; channel A also covers TOP in modes 9 and 11
		cmpf_nxt = cmpf_nxt | ch_match;
	end

	// Register control, prescaler, counter and flags.
	// count up from zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r            <= `DSPWM_CTRL_RST;
			capture_top_reg_r <= CNT_W'(`DSPWM_VAL_RST);
			pre_r             <= 10'h000;
			cnt_r             <= CNT_W'(`DSPWM_VAL_RST);
			dir_r             <= DSPWM_DIR_UP;
			ovf_r             <= 1'b0;
			capt_r            <= 1'b0;
			cmpf_r            <= '0;
		end else begin
			ctrl_r            <= ctrl_nxt;
			capture_top_reg_r <= capture_top_reg_nxt;
			pre_r             <= pre_nxt;
			cnt_r             <= cnt_nxt;
			dir_r             <= dir_nxt;
			ovf_r             <= ovf_nxt;
			capt_r            <= capt_nxt;
			cmpf_r            <= cmpf_nxt;
		end
	end

	// Compare channels, one per output.
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		dspwm_chan_cfg_s cfg;
		logic [1:0]      sel;

		assign sel                     = ctrl_r[`DSPWM_CTRL_COM_LSB + 2*i +: 2];
		assign cfg.output_select_field = sel;
		assign cfg.buffered            = (kind != DSPWM_KIND_OFF);
		// Toggle only on channel A with channel A defining TOP.
		assign cfg.toggle_ok           = (i == 0) &&
		                                 (waveform_select == `DSPWM_WGM_PFC_A ||
		                                  waveform_select == `DSPWM_WGM_PC_A);
		assign ch_wr[i]                = wr_acc &&
		                                 (paddr == `DSPWM_OFS_CMP_A + 12'(4*i));

		dspwm_channel #(
			.CNT_W (CNT_W)
		) u_ch (
			.clk               (clk),
			.resetn            (resetn),
			.timer_tick        (timer_tick && (kind != DSPWM_KIND_OFF)),
			.update_now        (update_now),
			.counter_value     (cnt_r),
			.top_value         (top_value),
			.dir               (dir_r),
			.cfg               (cfg),
			.wr_en             (ch_wr[i]),
			.wr_data           (pwdata[CNT_W-1:0]),
			.buf_value         (ch_buf[i]),
			.compare_value_reg (ch_act[i]),
			.match             (ch_match[i]),
			.out_level         (ch_out[i])
		);

		assign compare_output_pin[i] = ch_out[i];
		assign compare_output_oe[i]  = pin_direction_bit[i] &&
		                               (sel == `DSPWM_COM_NONINV || sel == `DSPWM_COM_INV ||
		                                (sel == `DSPWM_COM_TOGGLE && cfg.toggle_ok));
	end

endmodule
`default_nettype wire

// ===== dspwm_timer_chk.sv
// Port checker for the dual-slope PWM timer.
// Assumes it is bound to the timer top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "dspwm_defines.svh"

module dspwm_timer_chk #(
	parameter int NUM_CH = 3
) (
	// Clock and reset.
	input wire logic              clk,
	input wire logic              resetn,
	// APB slave side.
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Compare outputs.
	input wire logic [NUM_CH-1:0] compare_output_pin,
	input wire logic [NUM_CH-1:0] compare_output_oe
);
	logic [31:0] ctrl_r;	// Shadow of the control register.
	logic [31:0] ctrl_nxt;	// Its next value.
	logic        stop;	// Prescaler stopped by the shadow setting.

	// The shadow follows completed APB writes to the control word.
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (psel && penable && pready && pwrite && paddr == `DSPWM_OFS_CTRL) begin
			ctrl_nxt = pwdata;
		end
	end

	// Register the shadow.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= `DSPWM_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Clock-select codes 0, 6 and 7 give no timer tick.
	assign stop = (ctrl_r[6:4] == `DSPWM_CS_STOP) || (ctrl_r[6:4] > `DSPWM_CS_DIV1024);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Three cycles without a tick let any pending output update land.
	sequence s_stopped;
		stop [*3];
	endsequence

	a_ready_high: assert property (pready)
		else $error("pready was low");
	a_err_unmapped: assert property (psel && penable && paddr > 12'h018 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_bus_quiet: assert property (!(psel && penable) |-> !pslverr && prdata == 32'h0)
		else $error("response outside access phase");
	a_oe_needs_dir: assert property (compare_output_oe[0] |-> ctrl_r[16])
		else $error("pin driven without direction bit");
	a_oe_unselected: assert property (ctrl_r[11:10] == 2'h0 |-> !compare_output_oe[1])
		else $error("unselected channel drives pin");
	a_toggle_only_a: assert property (ctrl_r[11:10] == `DSPWM_COM_TOGGLE |-> !compare_output_oe[1])
		else $error("toggle mode connected on channel B");
	a_pin_stopped: assert property (s_stopped |-> $stable(compare_output_pin))
		else $error("output moved with no timer tick");
	a_reset_clear: assert property ($rose(resetn) |-> compare_output_pin == '0 && compare_output_oe == '0)
		else $error("outputs not low after reset");
endmodule

bind dspwm_timer dspwm_timer_chk #(.NUM_CH(NUM_CH)) u_chk (
	.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe)
);
`default_nettype wire

// ===== dspwm_pin_model.sv
// Model of the port pins: resolves each pin and counts its high cycles.
// Assumes pins have a pull-down when the timer does not drive them.
`timescale 1ns/1ps
`default_nettype none

module dspwm_pin_model (
	// Clock.
	input wire logic        clk,
	// Timer outputs.
	input wire logic [2:0]  pin,
	input wire logic [2:0]  oe,
	// Measurement window, high while counting.
	input wire logic        meas,
	// Pin levels and high-cycle counts.
	output logic [2:0]       level,
	output logic [2:0][15:0] hi_cnt
);
	logic meas_q;	// Window level of the last cycle.

	assign level = pin & oe;

	// Counts restart on the first cycle of each window.
	always_ff @(posedge clk) begin
		meas_q <= meas;
		for (int i = 0; i < 3; i++) begin
			if (meas && !meas_q) begin
				hi_cnt[i] <= {15'h0, level[i]};
			end else if (meas) begin
				hi_cnt[i] <= hi_cnt[i] + {15'h0, level[i]};
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb_dual_slope_pwm_timer16.sv
// Testbench for the dual-slope PWM timer: APB tasks and waveform runs.
// Assumes the checker is bound and the pin model sits on the outputs.
`timescale 1ns/1ps
`default_nettype none
`include "dspwm_defines.svh"

module tb_dual_slope_pwm_timer16;
	logic clk = 1'b0, resetn = 1'b0;	// Clock and reset.
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;	// APB controls.
	logic [11:0] paddr = 12'h0;	// APB address.
	logic [31:0] pwdata = 32'h0, prdata, rdat;	// APB data.
	logic pready, pslverr, rerr, meas = 1'b0;	// Responses and window.
	logic [2:0] pin, oe, level;	// Pins.
	logic [2:0][15:0] hi_cnt;	// High counts from the pin model.
	int failures = 0, compares = 0;	// Verdict counters.

	dspwm_timer #(.CNT_W(16), .NUM_CH(3)) dut (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .compare_output_pin(pin), .compare_output_oe(oe));
	dspwm_pin_model u_pins (.clk(clk), .pin(pin), .oe(oe), .meas(meas), .level(level),
		.hi_cnt(hi_cnt));

	// The clock toggles every half period of 20 ns.
	initial begin
		forever #20 clk = ~clk;
	end

	// Compare a seen value with the expected one.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Print the verdict and stop.
	task automatic results();
		if (failures == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One APB transfer; read data and error land in rdat and rerr.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Hold the access phase until pready is seen high; the watchdog ends a hang.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Run one mode: B non-inverted, C inverted but undriven, A toggle, TOP of 3 except under the fixed-TOP codes.
	task automatic run(input logic [3:0] wgm, input logic [2:0] cs, input logic [15:0] b,
		input logic [15:0] c, input int n, input logic [15:0] ea, input logic [15:0] eb,
		input logic [15:0] ec, input logic [31:0] ef);
		logic [31:0] rawc;	// Raw high cycles of channel C; an unknown pin stays unknown.
		apb(1'b1, `DSPWM_OFS_CMP_B, {16'h0, b});
		apb(1'b1, `DSPWM_OFS_CMP_C, {16'h0, c});
		apb(1'b1, `DSPWM_OFS_CTRL, 32'h0003_3900 | {cs, wgm});
		repeat (n) @(posedge clk);
		rawc = 32'h0;
		meas <= 1'b1;
		repeat (n) begin
			@(posedge clk);
			rawc += {31'h0, pin[2]};
		end
		meas <= 1'b0;
		@(posedge clk);
		chk(hi_cnt[0], ea);
		chk(hi_cnt[1], eb);
		chk(hi_cnt[2], 16'h0);
		chk(rawc, ec);
		apb(1'b1, `DSPWM_OFS_CTRL, 32'h0003_3900 | wgm);
		apb(1'b0, `DSPWM_OFS_FLAGS, 32'h0);
		chk(rdat, ef);
		apb(1'b1, `DSPWM_OFS_FLAGS, 32'h1f);
		apb(1'b0, `DSPWM_OFS_FLAGS, 32'h0);
		chk(rdat, 32'h0);
	endtask

	// Watchdog against a hung run.
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end

	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		apb(1'b0, `DSPWM_OFS_CTRL, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b1, `DSPWM_OFS_COUNT, 32'h5);
		apb(1'b0, `DSPWM_OFS_COUNT, 32'h0);
		chk(rdat, 32'h0);
		// An unmapped read is refused with an error and zero data.
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk(rdat, 32'h0);
		// Toggle on A and B outside codes 9 and 11 leaves both pins undriven.
		apb(1'b1, `DSPWM_OFS_CTRL, 32'h0003_0500);
		// TOP of 3 from both sources
		apb(1'b1, `DSPWM_OFS_CAPTOP, 32'h3);
		chk({29'h0, oe}, 32'h0);
		apb(1'b1, `DSPWM_OFS_CMP_A, 32'h3);
		run(4'h8, 3'h1, 16'h1, 16'h1, 60, 16'd0, 16'd20, 16'd40, 32'h1f);
		run(4'h9, 3'h1, 16'h1, 16'h1, 60, 16'd30, 16'd20, 16'd40, 32'h1d);
		run(4'ha, 3'h1, 16'h1, 16'h1, 60, 16'd0, 16'd20, 16'd40, 32'h1f);
		run(4'hb, 3'h1, 16'h1, 16'h1, 60, 16'd30, 16'd20, 16'd40, 32'h1d);
		run(4'h9, 3'h2, 16'h1, 16'h1, 96, 16'd48, 16'd32, 16'd64, 32'h1d);
		run(4'h9, 3'h1, 16'h0, 16'h0, 60, 16'd30, 16'd0, 16'd60, 32'h1d);
		run(4'hb, 3'h1, 16'h3, 16'h3, 60, 16'd30, 16'd60, 16'd0, 32'h1d);
		// Slow prescaler, then the fixed TOP last: a lower TOP after it would wrap.
		run(4'h8, 3'h3, 16'h1, 16'h1, 384, 16'd0, 16'd128, 16'd256, 32'h1f);
		run(4'h1, 3'h1, 16'h1, 16'h1, 510, 16'd0, 16'd2, 16'd508, 32'h1d);
		results();
	end
endmodule
`default_nettype wire
